/* rtl/imf_regs.v */
// Design decision made here: register access over APB.
`timescale 1ns/100ps
`include "imf_defs.vh"
module imf_regs #(
	parameter DW = 8
) (
	// Clock and reset
	input  wire          pclk,
	input  wire          presetn,
	// APB
	input  wire          psel,
	input  wire          penable,
	input  wire          pwrite,
	input  wire [11:0]   paddr,
	input  wire [31:0]   pwdata,
	output reg  [31:0]   prdata,
	output reg           pready,
	output reg           pslverr,
	// Interrupt sources
	input  wire [31:0]   src_events,
	input  wire [DW-1:0] tx_free_blocks,
	input  wire [DW-1:0] tx_status_used,
	input  wire [DW-1:0] rx_status_used,
	// Receive data path
	input  wire          rx_rd_dword,
	input  wire          rx_pkt_last,
	output reg           rx_pad_dword,
	output reg  [1:0]    rx_byte_shift,
	output reg  [2:0]    rx_dword_skip,
	output reg           rx_flush,
	// Interrupt
	output reg           irq
);
	reg  [31:0] mask_r;
	reg  [31:0] status_r;
	reg  [31:0] levels_r;
	reg  [31:0] rxcfg_r;
	reg  [11:0] cnt_r;
	reg         cnt_run_r;
	reg  [31:0] rdata_nxt;
	reg  [31:0] set_nxt;
	wire        wr;
	wire        rd;
	wire        sel_ok;
	wire        tx_sp_above;
	wire        tx_st_above;
	wire        rx_st_above;
	wire        pad_w;
	wire [1:0]  shift_w;
	wire [2:0]  skip_w;
	wire        dma_done;

	assign wr = psel && penable && pwrite;
	assign rd = psel && penable && !pwrite;
	assign sel_ok = (paddr == `IMF_OFS_MASK) || (paddr == `IMF_OFS_PROBE) ||
		(paddr == `IMF_OFS_LEVELS) || (paddr == `IMF_OFS_RXCFG) ||
		(paddr == `IMF_OFS_STATUS);
	assign dma_done = rx_rd_dword && cnt_run_r && (cnt_r == 12'h001) &&
		!(wr && pready && (paddr == `IMF_OFS_RXCFG)); // R18

	imf_level_cmp #(.W(DW)) u_txsp (
		.pclk      (pclk),
		.presetn   (presetn),
		.level     (tx_free_blocks),
		.threshold (levels_r[31:24]),
		.above     (tx_sp_above)
	);
	imf_level_cmp #(.W(DW)) u_txst (
		.pclk      (pclk),
		.presetn   (presetn),
		.level     (tx_status_used),
		.threshold (levels_r[23:16]),
		.above     (tx_st_above)
	);
	imf_level_cmp #(.W(DW)) u_rxst (
		.pclk      (pclk),
		.presetn   (presetn),
		.level     (rx_status_used),
		.threshold (levels_r[7:0]),
		.above     (rx_st_above)
	);
	imf_rx_reader u_rd (
		.pclk        (pclk),
		.presetn     (presetn),
		.align       (rxcfg_r[31:30]),
		.lead_offset (rxcfg_r[12:8]),
		.flush       (rx_flush),
		.rd_dword    (rx_rd_dword),
		.pkt_last    (rx_pkt_last),
		.pad_dword   (pad_w),
		.byte_shift  (shift_w),
		.dword_skip  (skip_w),
		.pos_r       ()
	);

	// Event set vector
	always @* begin
		set_nxt = src_events & `IMF_MASK_WMASK;
		set_nxt[`IMF_TXSPACE_BIT] = set_nxt[`IMF_TXSPACE_BIT] | tx_sp_above; // R11
		set_nxt[`IMF_TXSTAT_BIT]  = set_nxt[`IMF_TXSTAT_BIT] | tx_st_above; // R12
		set_nxt[`IMF_RXSTAT_BIT]  = set_nxt[`IMF_RXSTAT_BIT] | rx_st_above; // R13
		set_nxt[`IMF_RXDMA_BIT]   = set_nxt[`IMF_RXDMA_BIT] | dma_done; // R17
	end

	// Read mux
	always @* begin
		case (paddr)
		`IMF_OFS_MASK:   rdata_nxt = mask_r;
		`IMF_OFS_PROBE:  rdata_nxt = `IMF_PROBE_VALUE; // R10
		`IMF_OFS_LEVELS: rdata_nxt = levels_r;
		`IMF_OFS_RXCFG:  rdata_nxt = {rxcfg_r[31:28], cnt_r, rxcfg_r[15:0]};
		`IMF_OFS_STATUS: rdata_nxt = status_r;
		default:         rdata_nxt = 32'h00000000;
		endcase
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mask_r        <= 32'h00000000;
			status_r      <= 32'h00000000;
			levels_r      <= `IMF_LEVELS_RESET;
			rxcfg_r       <= 32'h00000000;
			cnt_r         <= 12'h000;
			cnt_run_r     <= 1'b0;
			prdata        <= 32'h00000000;
			pready        <= 1'b0;
			pslverr       <= 1'b0;
			rx_flush      <= 1'b0;
			rx_pad_dword  <= 1'b0;
			rx_byte_shift <= 2'h0;
			rx_dword_skip <= 3'h0;
			irq           <= 1'b0;
		end else begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && !sel_ok;
			if (psel && !penable && !pwrite)
				prdata <= rdata_nxt;
			rx_flush <= 1'b0;
			if (wr && pready && paddr == `IMF_OFS_MASK)
				mask_r <= pwdata & `IMF_MASK_WMASK; // R03 R04 R05 R06 R07 R08 R09
			if (wr && pready && paddr == `IMF_OFS_LEVELS)
				levels_r <= pwdata & `IMF_LEVELS_WMASK; // R11 R12 R13
			if (wr && pready && paddr == `IMF_OFS_RXCFG) begin
				rxcfg_r <= pwdata & `IMF_RXCFG_WMASK & 32'hFFFF7FFF; // R20
				rx_flush <= pwdata[`IMF_FLUSH_BIT]; // R19
			end
			// Countdown: write replaces running count
			if (wr && pready && paddr == `IMF_OFS_RXCFG) begin
				cnt_r     <= pwdata[27:16]; // R18
				cnt_run_r <= (pwdata[27:16] != 12'h000);
			end else if (rx_rd_dword && cnt_run_r) begin
				cnt_r <= cnt_r - 12'h001; // R17
				if (cnt_r == 12'h001)
					cnt_run_r <= 1'b0;
			end
			// Sticky status, set wins over write-one clear
			if (wr && pready && paddr == `IMF_OFS_STATUS)
				status_r <= (status_r & ~pwdata) | set_nxt; // R02
			else
				status_r <= status_r | set_nxt; // R02
			irq <= |(status_r & mask_r); // R01 R23
			rx_pad_dword  <= pad_w;
			rx_byte_shift <= shift_w;
			rx_dword_skip <= skip_w; // R22
		end
	end
endmodule // imf_regs

/* rtl/imf_defs.vh */
// Functional notes
// R01 - Set mask bit lets source drive interrupt
// R02 - Status flags record events regardless of mask
// R03 - Mask bits 31, 25, 24 read/write, reset zero
// R04 - Mask bits 23, 21, 20 reset zero
// R05 - Mask bits 19, 18, 17 reset zero
// R06 - Mask bits 16, 15, 14, 13
// R07 - Mask bits 10, 9, 8, 7, 6
// R08 - Mask bits 4, 3, 2-0 reset zero
// R09 - Unused mask bits read zero, ignore writes
// R10 - Fixed byte-order pattern register, read only
// R11 - Tx space event when blocks exceed threshold
// R12 - Tx status level event above threshold
// R13 - Rx status level event above threshold
// R14 - Pad read end to alignment boundary
// R15 - Alignment code: 4, 16, 32 bytes
// R16 - Host keeps alignment during packet read
// R17 - Countdown decrements per dword read, raises event
// R18 - Writing countdown replaces running count
// R19 - Self-clearing flush resets data/status pointers
// R20 - Lead offset 0-31 bytes before data
// R21 - Host changes low offset bits only halted
// R22 - Upper offset bits apply next dword read
// R23 - Interrupt asserted while flag and mask set
`ifndef IMF_DEFS_VH
`define IMF_DEFS_VH
`define IMF_OFS_MASK      12'h05C
`define IMF_OFS_PROBE     12'h064
`define IMF_OFS_LEVELS    12'h068
`define IMF_OFS_RXCFG     12'h06C
`define IMF_OFS_STATUS    12'h058
`define IMF_MASK_WMASK    32'h83BFE7DF
`define IMF_PROBE_VALUE   32'h87654321
`define IMF_LEVELS_WMASK  32'hFFFF00FF
`define IMF_LEVELS_RESET  32'h48000000
`define IMF_RXCFG_WMASK   32'hCFFF1F00
`define IMF_TXSPACE_BIT   9
`define IMF_TXSTAT_BIT    7
`define IMF_RXSTAT_BIT    3
`define IMF_RXDMA_BIT     20
`define IMF_FLUSH_BIT     15
`define IMF_ALIGN_4       2'h0
`define IMF_ALIGN_16      2'h1
`define IMF_ALIGN_32      2'h2
`endif

/* rtl/imf_level_cmp.v */
`timescale 1ns/100ps
module imf_level_cmp #(
	parameter W = 8
) (
	// Clock and reset
	input  wire         pclk,
	input  wire         presetn,
	// Compare
	input  wire [W-1:0] level,
	input  wire [W-1:0] threshold,
	output reg          above
);
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			above <= 1'b0;
		else
			above <= (level > threshold); // R11
	end
endmodule // imf_level_cmp

/* rtl/imf_rx_reader.v */
`timescale 1ns/100ps
`include "imf_defs.vh"
module imf_rx_reader (
	// Clock and reset
	input  wire        pclk,
	input  wire        presetn,
	// Configuration
	input  wire [1:0]  align,
	input  wire [4:0]  lead_offset,
	input  wire        flush,
	// Host data reads
	input  wire        rd_dword,
	input  wire        pkt_last,
	output reg         pad_dword,
	output reg  [1:0]  byte_shift,
	output reg  [2:0]  dword_skip,
	output reg  [2:0]  pos_r
);
	reg [2:0] pad_left_r;
	reg [2:0] span;
	always @* begin
		case (align) // R15
		`IMF_ALIGN_16: span = 3'h3;
		`IMF_ALIGN_32: span = 3'h7;
		default:       span = 3'h0;
		endcase
	end
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pos_r      <= 3'h0;
			pad_left_r <= 3'h0;
			pad_dword  <= 1'b0;
			byte_shift <= 2'h0;
			dword_skip <= 3'h0;
		end else begin
			byte_shift <= lead_offset[1:0]; // R20
			if (rd_dword)
				dword_skip <= lead_offset[4:2]; // R22
			pad_dword <= (pad_left_r != 3'h0);
			if (flush) begin
				pos_r      <= 3'h0;
				pad_left_r <= 3'h0;
			end else if (pad_left_r != 3'h0) begin
				pad_left_r <= pad_left_r - 3'h1; // R14
			end else if (rd_dword) begin
				pos_r <= (pos_r + 3'h1) & span;
				if (pkt_last) begin
					pad_left_r <= (~pos_r) & span; // R14
					pos_r      <= 3'h0;
				end
			end
		end
	end
endmodule // imf_rx_reader

/* tb/imf_sva.sv */
`timescale 1ns/100ps
module imf_sva (
	// Bus
	input wire        pclk,
	input wire        presetn,
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire        pready,
	input wire        pslverr,
	// Receive
	input wire        rx_flush,
	input wire [1:0]  rx_byte_shift
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire rd = pready && !pwrite;
	wire cfg = pready && pwrite && paddr == 12'h06C;
	chk_ready_after: assert property (psel && !penable |=> pready)
		else $error("no ready");
	chk_ready_single: assert property (pready |=> !pready)
		else $error("long ready");
	chk_err_ready: assert property (pslverr |-> pready)
		else $error("lone error");
	chk_probe_value: assert property (
		rd && paddr == 12'h064 |-> prdata == 32'h87654321)
		else $error("bad probe");
	chk_mask_spare: assert property (
		rd && paddr == 12'h05C |-> (prdata & 32'h7C401820) == 0)
		else $error("spare mask bit");
	chk_cfg_spare: assert property (
		rd && paddr == 12'h06C |-> (prdata & 32'h3000E0FF) == 0)
		else $error("spare cfg bit");
	chk_flush_pulse: assert property (
		cfg && pwdata[15] |=> rx_flush ##1 !rx_flush)
		else $error("no flush pulse");
	chk_shift_follow: assert property (
		cfg |=> ##2 rx_byte_shift == $past(pwdata[9:8], 3))
		else $error("bad shift");
endmodule // imf_sva

/* tb/imf_host.sv */
`timescale 1ns/100ps
module imf_host (
	// Clock
	input  wire        pclk,
	// Request
	output reg         psel = 1'b0,
	output reg         penable = 1'b0,
	output reg         pwrite = 1'b0,
	output reg  [11:0] paddr = 12'h000,
	output reg  [31:0] pwdata = 32'h0,
	// Answer
	input  wire [31:0] prdata,
	input  wire        pready,
	input  wire        pslverr
);
	task xfer(input w, input [11:0] a, input [31:0] d, output [31:0] r,
		output e);
		begin
			@(posedge pclk);
			psel <= 1'b1;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge pclk);
			penable <= 1'b1;
			@(posedge pclk);
			while (!pready)
				@(posedge pclk);
			r = prdata;
			e = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask
endmodule // imf_host

/* tb/irq_mask_fifo_level_rx_config_bench.sv */
`timescale 1ns/100ps
module irq_mask_fifo_level_rx_config_bench;
	reg         pclk = 1'b0;
	reg         presetn = 1'b0;
	reg  [7:0]  txf = 8'h00;
	reg  [7:0]  txs = 8'h00;
	reg  [7:0]  rxs = 8'h00;
	reg         rdw = 1'b0;
	reg         last = 1'b0;
	reg  [31:0] ev = 32'h0;
	reg  [31:0] rd;
	reg         err;
	wire        pad;
	wire        psel, penable, pwrite, pready, pslverr, irq, flush;
	wire [11:0] paddr;
	wire [31:0] pwdata, prdata;
	wire [1:0]  bs;
	wire [2:0]  skip;
	integer     bad_count = 0;
	integer     checks_done = 0;
	always #2 pclk = ~pclk;
	imf_host imf_host_i (.pclk(pclk), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr));
	imf_regs imf_regs_i (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.src_events(ev), .tx_free_blocks(txf), .tx_status_used(txs),
		.rx_status_used(rxs), .rx_rd_dword(rdw), .rx_pkt_last(last),
		.rx_pad_dword(pad), .rx_byte_shift(bs), .rx_dword_skip(skip),
		.rx_flush(flush), .irq(irq));
	task check(input [31:0] seen, input [31:0] want);
		begin
			checks_done = checks_done + 1;
			if (seen !== want) begin
				bad_count = bad_count + 1;
				$display("unexpected at %0t: %h not %h", $time, seen, want);
			end
		end
	endtask
	task wr(input [11:0] a, input [31:0] d);
		imf_host_i.xfer(1'b1, a, d, rd, err);
	endtask
	task rdc(input [11:0] a, input [31:0] m, input [31:0] w);
		begin
			imf_host_i.xfer(1'b0, a, 32'h0, rd, err);
			check(rd & m, w);
		end
	endtask
	task words(input integer n);
		begin
			rdw <= 1'b1;
			repeat (n) @(posedge pclk);
			rdw <= 1'b0;
		end
	endtask
	task t_regs;
		begin
			rdc(12'h05C, 32'hFFFFFFFF, 32'h0);
			wr(12'h064, 32'h0);
			rdc(12'h064, 32'hFFFFFFFF, 32'h87654321);
			check({31'h0, err}, 32'h0);
			rdc(12'h068, 32'hFFFFFFFF, 32'h48000000);
			rdc(12'h060, 32'hFFFFFFFF, 32'h0);
			check({31'h0, err}, 32'h1);
			wr(12'h05C, 32'hFFFFFFFF);
			rdc(12'h05C, 32'hFFFFFFFF, 32'h83BFE7DF);
			$display("regs done");
		end
	endtask
	task t_irq;
		begin
			wr(12'h05C, 32'h200);
			txf <= 8'h48;
			repeat (4) @(posedge pclk);
			check({31'h0, irq}, 32'h0);
			txf <= 8'h49;
			repeat (4) @(posedge pclk);
			check({31'h0, irq}, 32'h1);
			wr(12'h05C, 32'h0);
			repeat (2) @(posedge pclk);
			check({31'h0, irq}, 32'h0);
			wr(12'h068, 32'h00030002);
			txs <= 8'h03;
			rxs <= 8'h03;
			repeat (2) @(posedge pclk);
			rdc(12'h058, 32'h288, 32'h208);
			txs <= 8'h04;
			repeat (2) @(posedge pclk);
			rdc(12'h058, 32'h88, 32'h88);
			// Masked source still recorded, reserved source dropped
			ev <= 32'hC0000000;
			@(posedge pclk);
			ev <= 32'h0;
			rdc(12'h058, 32'hC0000000, 32'h80000000);
			wr(12'h05C, 32'h80000000);
			repeat (2) @(posedge pclk);
			check({31'h0, irq}, 32'h1);
			$display("irq done");
		end
	endtask
	task t_rx;
		begin
			wr(12'h06C, 32'h00050000);
			words(2);
			wr(12'h06C, 32'h00020000);
			words(1);
			rdc(12'h06C, 32'h0FFF0000, 32'h00010000);
			rdc(12'h058, 32'h100000, 32'h0);
			words(1);
			rdc(12'h058, 32'h100000, 32'h100000);
			// Low offset bits set while reception idles
			wr(12'h06C, 32'h00001D00);
			rdc(12'h06C, 32'hFFFFFFFF, 32'h00001D00);
			check({30'h0, bs}, 32'h1);
			words(1);
			wr(12'h06C, 32'h00000D00);
			check({29'h0, skip}, 32'h7);
			words(1);
			repeat (2) @(posedge pclk);
			check({29'h0, skip}, 32'h3);
			wr(12'h06C, 32'h00008D00);
			rdc(12'h06C, 32'hFFFFFFFF, 32'h00000D00);
			$display("rx done");
		end
	endtask
	task packet(input integer n, input integer want);
		integer i;
		integer seen;
		begin
			seen = 0;
			for (i = 1; i <= n; i = i + 1) begin
				rdw  <= 1'b1;
				last <= (i == n);
				@(posedge pclk);
			end
			rdw  <= 1'b0;
			last <= 1'b0;
			repeat (10) begin
				@(posedge pclk);
				seen = seen + pad;
			end
			check(seen, want);
		end
	endtask
	task t_pad;
		begin
			// Alignment set between packets, low offset bits kept
			wr(12'h06C, 32'h40000D00);
			packet(2, 2);
			wr(12'h06C, 32'h80000D00);
			packet(3, 5);
			wr(12'h06C, 32'h00000D00);
			packet(3, 0);
			$display("pad done");
		end
	endtask
	task print_verdict;
		begin
			$display("checks %0d mismatches %0d", checks_done, bad_count);
			if (bad_count == 0 && checks_done > 0)
				$display("Test passed");
			else
				$display("Test failed");
			$finish;
		end
	endtask
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		t_regs;
		t_irq;
		t_rx;
		t_pad;
		print_verdict;
	end
	initial begin
		#20000;
		bad_count = bad_count + 1;
		print_verdict;
	end
endmodule // irq_mask_fifo_level_rx_config_bench
bind imf_regs imf_sva imf_sva_i (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.rx_flush(rx_flush), .rx_byte_shift(rx_byte_shift));
